// file: common/chgst_map.svh
// Register indices, bus geometry and reset values of the charger status bank.
// Assumes each register index is one 32-bit APB word: byte address is index times four.
// Function
// - Status word one holds temp reduce, restart, foldback, timeout flags and state code.
// - Restart flag reads one during charger restart, gated by charger enable.
// - Thermal foldback flag needs line voltage present and charger enabled.
// - Timeout flag reads one once the first constant-current timer has expired.
// - State codes 0x0 to 0x7 report off through maintain charge done.
// - Codes 0x8 and 0x9 report timer faults, 0xF reports temperature suspend.
// - Status word two bit seven reads one while input current sits at limit.
// - Bits six to one carry the live input limit code; bit zero unused.
// - Status word three bit seven reads one when system rail sits at minimum.
// - Bit six reads zero while the charger is in reverse protection.
// - Bit five shows battery regulation; bit four step charge, gated by enable.
// - Bits three and two show charger and regulator dropout, each gated.
// - Bit one reads one while line input voltage is above detection.
// - Bit zero reads zero while the system regulator is in reverse protection.
`ifndef CHGST_MAP_SVH
`define CHGST_MAP_SVH

`define CHGST_ADDR_W 8
`define CHGST_IDX_W 6

`define CHGST_IDX_STATE 6'h02
`define CHGST_IDX_LIMIT 6'h03
`define CHGST_IDX_PATH 6'h04
`define CHGST_IDX_EVT_STS 6'h08
`define CHGST_IDX_EVT_EN 6'h09
`define CHGST_IDX_EVT_CLR 6'h0a

`define CHGST_RST_STATE 8'h00
`define CHGST_RST_LIMIT 8'h00
`define CHGST_RST_PATH 8'h00
`define CHGST_RST_EVT 8'h00
`define CHGST_RST_EN 8'h00

`endif

// file: common/chgst_pkg.sv
// Types of the charger status bank: state codes, condition bundle, register layouts.
// Assumes chgst_map.svh is on the include path.
`include "chgst_map.svh"
package chgst_pkg;

	typedef enum logic [3:0] {
		chgst_off = 4'h0,
		chgst_idle = 4'h1,
		chgst_prechg = 4'h2,
		chgst_cc_first = 4'h3,
		chgst_cc_second = 4'h4,
		chgst_cv = 4'h5,
		chgst_maint = 4'h6,
		chgst_maint_done = 4'h7,
		chgst_flt_prechg_tmr = 4'h8,
		chgst_flt_charge_tmr = 4'h9,
		chgst_temp_suspend = 4'hf
	} chgst_code_t;

	typedef struct packed {
		logic temp_standard_reduce;
		logic restart;
		logic thermal_foldback;
		logic input_limit_active;
		logic sys_reference;
		logic charger_reverse;
		logic battery_regulation;
		logic step_charge;
		logic charger_dropout;
		logic regulator_dropout;
		logic line_voltage_present;
		logic regulator_reverse;
	} chgst_cond_t;

	typedef struct packed {
		logic temp_standard_reduce_flag;
		logic charger_restart_flag;
		logic thermal_foldback_flag;
		logic first_cc_timeout_flag;
		logic [3:0] charger_state_code;
	} chgst_state_t;

	typedef struct packed {
		logic input_limit_active_flag;
		logic [5:0] live_input_limit_code;
		logic unused;
	} chgst_limit_t;

	typedef struct packed {
		logic sys_reference_flag;
		logic charger_reverse_flag;
		logic battery_regulation_flag;
		logic step_charge_flag;
		logic charger_dropout_flag;
		logic regulator_dropout_flag;
		logic line_voltage_present_flag;
		logic regulator_reverse_flag;
	} chgst_path_t;

	typedef struct packed {
		logic state_change;
		logic fault_entry;
		logic cc_timeout;
		logic line_change;
		logic thermal_entry;
		logic restart_entry;
		logic limit_entry;
		logic reverse_entry;
	} chgst_evt_t;

endpackage : chgst_pkg

// file: verilog/chgst_sync.sv
// Two-flop synchroniser for a bundle of asynchronous level inputs.
// Assumes each bit is an independent level; bits may resolve in different cycles.
`timescale 1ns/1ps
`default_nettype none

module chgst_sync #(
	parameter int W = 1
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	// The first stage is read by the second stage only.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_r <= '0;
			sync_r <= '0;
		end
		else
		begin
			meta_r <= d;
			sync_r <= meta_r;
		end
	end

	assign q = sync_r;

endmodule : chgst_sync
`default_nettype wire

// file: verilog/chgst_regs.sv
// Charger status bank: three read-only status words and an event interrupt block on APB.
// Assumes analog condition flags are asynchronous to pclk, while the state code,
// live limit code, timeout flag and the two enables come from pclk logic.
`timescale 1ns/1ps
`default_nettype none
`include "chgst_map.svh"

module chgst_regs
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`CHGST_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	output logic irq,
	input wire logic charger_enable_setting,
	input wire logic regulator_active,
	input wire logic [3:0] charger_state_code,
	input wire logic [5:0] live_input_limit_code,
	input wire logic first_cc_timeout_flag,
	input wire chgst_pkg::chgst_cond_t cond_async
);

	chgst_pkg::chgst_cond_t cond_sync;

	chgst_pkg::chgst_state_t state_r;
	chgst_pkg::chgst_state_t state_nxt;
	chgst_pkg::chgst_limit_t limit_r;
	chgst_pkg::chgst_limit_t limit_nxt;
	chgst_pkg::chgst_path_t path_r;
	chgst_pkg::chgst_path_t path_nxt;

	chgst_pkg::chgst_evt_t evt;
	chgst_pkg::chgst_evt_t evt_sts_r;
	chgst_pkg::chgst_evt_t evt_sts_nxt;
	chgst_pkg::chgst_evt_t evt_en_r;
	chgst_pkg::chgst_evt_t evt_en_nxt;
	chgst_pkg::chgst_evt_t evt_clr;
	logic irq_r;
	logic irq_nxt;

	logic [`CHGST_IDX_W-1:0] idx;
	logic setup;
	logic wr_access;
	logic hit;
	logic [31:0] rd_word;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pslverr_r;
	logic pslverr_nxt;
	logic rd_setup;
	logic wr_en_hit;
	logic wr_clr_hit;

	logic code_is_fault;
	logic code_was_fault;

	// Comparator outputs settle on their own time, so every one is synchronised.
	// A flag that moves just before a read may show either level; a second read settles it.
	chgst_sync #(
		.W($bits(chgst_pkg::chgst_cond_t))
	)
	u_cond_sync
	(
		.clk(pclk),
		.rst_n(presetn),
		.d(cond_async),
		.q(cond_sync)
	);

	// Status word one: qualified charger flags and the raw state code.
	always_comb
	begin
		state_nxt = state_r;
		state_nxt.temp_standard_reduce_flag = cond_sync.temp_standard_reduce;
		// A restart flag with the charger off is stale, so it is masked.
		state_nxt.charger_restart_flag = cond_sync.restart
			& charger_enable_setting;
		state_nxt.thermal_foldback_flag = cond_sync.thermal_foldback
			& cond_sync.line_voltage_present
			& charger_enable_setting;
		state_nxt.first_cc_timeout_flag = first_cc_timeout_flag;
		// Reserved codes pass through unchanged so a fault upstream stays visible.
		state_nxt.charger_state_code = charger_state_code;
	end

	// Status word two: input limit state and live limit code.
	always_comb
	begin
		limit_nxt = limit_r;
		limit_nxt.input_limit_active_flag = cond_sync.input_limit_active;
		limit_nxt.live_input_limit_code = live_input_limit_code;
		limit_nxt.unused = 1'b0;
	end

	// Status word three: power path flags, some gated by the path that owns them.
	always_comb
	begin
		path_nxt = path_r;
		path_nxt.sys_reference_flag = cond_sync.sys_reference;
		path_nxt.charger_reverse_flag = cond_sync.charger_reverse;
		path_nxt.battery_regulation_flag = cond_sync.battery_regulation;
		path_nxt.step_charge_flag = cond_sync.step_charge
			& charger_enable_setting;
		// Gates use the synchronised line flag, so a gate and the flag it gates move together.
		path_nxt.charger_dropout_flag = cond_sync.charger_dropout
			& cond_sync.line_voltage_present
			& charger_enable_setting;
		path_nxt.regulator_dropout_flag = cond_sync.regulator_dropout
			& cond_sync.line_voltage_present
			& regulator_active;
		path_nxt.line_voltage_present_flag = cond_sync.line_voltage_present;
		path_nxt.regulator_reverse_flag = cond_sync.regulator_reverse;
	end

	// The status words have no write path at all, so bus writes cannot touch them.
	// Every field resets to zero and then follows its source from the first edge.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= `CHGST_RST_STATE;
			limit_r <= `CHGST_RST_LIMIT;
			path_r <= `CHGST_RST_PATH;
		end
		else
		begin
			state_r <= state_nxt;
			limit_r <= limit_nxt;
			path_r <= path_nxt;
		end
	end

	// Events compare the next status value with the one on display.
	always_comb
	begin
		code_is_fault = 1'b0;
		code_was_fault = 1'b0;
		unique case (state_nxt.charger_state_code)
			chgst_pkg::chgst_flt_prechg_tmr,
			chgst_pkg::chgst_flt_charge_tmr,
			chgst_pkg::chgst_temp_suspend:
			begin
				code_is_fault = 1'b1;
			end
			default:
			begin
				code_is_fault = 1'b0;
			end
		endcase
		unique case (state_r.charger_state_code)
			chgst_pkg::chgst_flt_prechg_tmr,
			chgst_pkg::chgst_flt_charge_tmr,
			chgst_pkg::chgst_temp_suspend:
			begin
				code_was_fault = 1'b1;
			end
			default:
			begin
				code_was_fault = 1'b0;
			end
		endcase
	end

	always_comb
	begin
		evt = '0;
		// After reset the synchronisers start at zero, so a line already present at
		// power-up reports one line change about three edges after release.
		// Entering a fault code sets both the state change and the fault bit.
		evt.state_change = state_nxt.charger_state_code
			!= state_r.charger_state_code;
		evt.fault_entry = code_is_fault & ~code_was_fault;
		evt.cc_timeout = state_nxt.first_cc_timeout_flag
			& ~state_r.first_cc_timeout_flag;
		evt.line_change = path_nxt.line_voltage_present_flag
			!= path_r.line_voltage_present_flag;
		evt.thermal_entry = state_nxt.thermal_foldback_flag
			& ~state_r.thermal_foldback_flag;
		evt.restart_entry = state_nxt.charger_restart_flag
			& ~state_r.charger_restart_flag;
		evt.limit_entry = limit_nxt.input_limit_active_flag
			& ~limit_r.input_limit_active_flag;
		// Reverse protection is the active-low reading of either reverse flag.
		evt.reverse_entry = (~path_nxt.charger_reverse_flag
			& path_r.charger_reverse_flag)
			| (~path_nxt.regulator_reverse_flag
			& path_r.regulator_reverse_flag);
	end

	// Bus phase decode; one word per register, low address bits ignored.
	// Only the two interrupt control words have write strobes: a write to a
	// status word decodes to nothing, which is what keeps those words read-only.
	always_comb
	begin
		idx = paddr[`CHGST_ADDR_W-1:2];
		setup = psel & ~penable;
		rd_setup = setup & ~pwrite;
		wr_access = psel & penable & pwrite;
		wr_en_hit = wr_access & (idx == `CHGST_IDX_EVT_EN);
		wr_clr_hit = wr_access & (idx == `CHGST_IDX_EVT_CLR);
	end

	// Interrupt block: sticky status, enable mask, write-one-to-clear.
	// The interrupt line is registered from the next status and next enable, so it
	// moves on the same edge as the bit that causes it.
	always_comb
	begin
		evt_clr = '0;
		evt_en_nxt = evt_en_r;
		evt_sts_nxt = evt_sts_r;
		if (wr_clr_hit)
		begin
			evt_clr = chgst_pkg::chgst_evt_t'(pwdata[7:0]);
		end
		if (wr_en_hit)
		begin
			evt_en_nxt = chgst_pkg::chgst_evt_t'(pwdata[7:0]);
		end
		// Each bit is cleared first and set last, so an event that lands in the
		// clearing cycle is kept: the set wins.
		for (int i = 0; i < $bits(chgst_pkg::chgst_evt_t); i++)
		begin
			if (evt_clr[i])
			begin
				evt_sts_nxt[i] = 1'b0;
			end
			if (evt[i])
			begin
				evt_sts_nxt[i] = 1'b1;
			end
		end
		irq_nxt = |(evt_sts_nxt & evt_en_nxt);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			evt_sts_r <= `CHGST_RST_EVT;
			evt_en_r <= `CHGST_RST_EN;
			irq_r <= 1'b0;
		end
		else
		begin
			evt_sts_r <= evt_sts_nxt;
			evt_en_r <= evt_en_nxt;
			irq_r <= irq_nxt;
		end
	end

	// Read mux; the clear register is write-only and reads as zero.
	always_comb
	begin
		rd_word = 32'h0000_0000;
		hit = 1'b1;
		case (idx)
			`CHGST_IDX_STATE:
			begin
				rd_word = {24'h00_0000, state_r};
			end
			`CHGST_IDX_LIMIT:
			begin
				rd_word = {24'h00_0000, limit_r};
			end
			`CHGST_IDX_PATH:
			begin
				rd_word = {24'h00_0000, path_r};
			end
			`CHGST_IDX_EVT_STS:
			begin
				rd_word = {24'h00_0000, evt_sts_r};
			end
			`CHGST_IDX_EVT_EN:
			begin
				rd_word = {24'h00_0000, evt_en_r};
			end
			`CHGST_IDX_EVT_CLR:
			begin
				rd_word = 32'h0000_0000;
			end
			default:
			begin
				hit = 1'b0;
			end
		endcase
	end

	// Read data and error are loaded in the setup cycle so that the single
	// access cycle can complete with no wait state.
	always_comb
	begin
		prdata_nxt = prdata_r;
		pslverr_nxt = pslverr_r;
		if (setup)
		begin
			pslverr_nxt = ~hit;
			// An unmapped read leaves the last read data in place.
			if (rd_setup && hit)
			begin
				prdata_nxt = rd_word;
			end
		end
		// The error is dropped at the edge that ends the access, so an idle bus
		// never shows a stale error from the transfer before.
		else if (!psel || penable)
		begin
			pslverr_nxt = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end
		else
		begin
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// Writes to the status words are accepted without error and have no effect.
	// The bank never stalls: read data is prepared in the setup cycle instead.
	assign pready = 1'b1;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
	assign irq = irq_r;

endmodule : chgst_regs
`default_nettype wire

// file: sim/chgst_regs_monitor.sv
// Port checker for the charger status bank.
// Assumes it is bound to chgst_regs and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module chgst_regs_monitor
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic irq,
	input wire logic charger_enable_setting,
	input wire logic regulator_active,
	input wire logic [3:0] charger_state_code,
	input wire logic [5:0] live_input_limit_code,
	input wire logic first_cc_timeout_flag,
	input wire chgst_pkg::chgst_cond_t cond_async
);
	logic [5:0] idx;
	logic acc;
	logic rd;
	logic mapped;
	assign idx = paddr[7:2];
	assign acc = psel && penable;
	assign rd = psel && !penable && !pwrite;
	assign mapped = idx inside {6'h02, 6'h03, 6'h04, 6'h08, 6'h09, 6'h0a};
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	ready_now_a: assert property (acc |-> pready) else $error("no ready");
	upper_zero_a: assert property (prdata[31:8] == 24'h0) else $error("upper bits");
	state_copy_a: assert property (rd && idx == 6'h02 |=>
		prdata[4:0] == {$past(first_cc_timeout_flag, 2), $past(charger_state_code, 2)})
		else $error("state word");
	limit_copy_a: assert property (rd && idx == 6'h03 |=>
		prdata[6:0] == {$past(live_input_limit_code, 2), 1'b0}) else $error("limit word");
	unmapped_err_a: assert property (acc && !mapped |-> pslverr) else $error("no error");
	mapped_ok_a: assert property (acc && mapped |-> !pslverr) else $error("bad error");
	idle_err_a: assert property (!psel |-> !pslverr) else $error("stray error");
	clear_reads_a: assert property (acc && !pwrite && idx == 6'h0a |-> prdata == 32'h0)
		else $error("clear reg read");
	mask_irq_a: assert property (acc && pwrite && idx == 6'h09 && pwdata[7:0] == 8'h00
		|=> !irq) else $error("irq not masked");
	cover property (rd && idx == 6'h02);
	cover property ($rose(irq));
	cover property (acc && pslverr);
endmodule : chgst_regs_monitor
bind chgst_regs chgst_regs_monitor chgst_regs_monitor_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
	.charger_enable_setting(charger_enable_setting), .regulator_active(regulator_active),
	.charger_state_code(charger_state_code), .live_input_limit_code(live_input_limit_code),
	.first_cc_timeout_flag(first_cc_timeout_flag), .cond_async(cond_async));
`default_nettype wire

// file: sim/chgst_regs_tb.sv
// Self-checking bench for the charger status bank over APB.
// Assumes conditions settle within four cycles; every bus wait is bounded.
`timescale 1ns/1ps
`default_nettype none
module chgst_regs_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, en, ract, tmo, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] code;
	logic [5:0] lim;
	chgst_pkg::chgst_cond_t cnd;
	int failures, cmp_count;
	chgst_regs chgst_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .irq(irq), .charger_enable_setting(en), .regulator_active(ract),
		.charger_state_code(code), .live_input_limit_code(lim), .first_cc_timeout_flag(tmo),
		.cond_async(cnd));
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic conclude;
		if (failures == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Each transfer starts one edge after the last release, so no signal is set twice.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16)
		begin
			failures++;
			$display("MISMATCH %0t bus access never completed", $time);
			conclude();
		end
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdc
	task automatic chki(input logic exp);
		@(negedge pclk);
		chk({31'h0, irq}, {31'h0, exp});
		@(posedge pclk);
	endtask : chki
	task automatic t_state;
		logic [3:0] c[11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hf};
		rdc(8'h08, 32'h0);
		rdc(8'h10, 32'h0);
		foreach (c[i])
		begin
			code <= c[i];
			repeat (2) @(posedge pclk);
			rdc(8'h08, {28'h0, c[i]});
		end
		{en, tmo, cnd.temp_standard_reduce, cnd.restart, cnd.thermal_foldback} <= 5'h1f;
		cnd.line_voltage_present <= 1'b1;
		code <= 4'h5;
		repeat (4) @(posedge pclk);
		rdc(8'h08, 32'hf5);
		{en, tmo} <= 2'h0;
		repeat (4) @(posedge pclk);
		rdc(8'h08, 32'h85);
	endtask : t_state
	task automatic t_path;
		{cnd.sys_reference, cnd.battery_regulation, cnd.step_charge} <= 3'h7;
		{cnd.charger_dropout, cnd.regulator_dropout, en, ract} <= 4'hf;
		{cnd.input_limit_active, lim} <= 7'h6a;
		repeat (4) @(posedge pclk);
		rdc(8'h10, 32'hbe);
		rdc(8'h0c, 32'hd4);
		{en, ract, cnd.input_limit_active, lim} <= 9'h03f;
		repeat (4) @(posedge pclk);
		rdc(8'h10, 32'ha2);
		rdc(8'h0c, 32'h7e);
		{cnd.charger_reverse, cnd.regulator_reverse, cnd.line_voltage_present} <= 3'h6;
		repeat (4) @(posedge pclk);
		rdc(8'h10, 32'he1);
		apb(1'b1, 8'h10, 32'hff);
		rdc(8'h10, 32'he1);
		apb(1'b1, 8'h0c, 32'h00);
		rdc(8'h0c, 32'h7e);
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, err}, 32'h1);
	endtask : t_path
	task automatic t_irq;
		apb(1'b1, 8'h28, 32'hff);
		apb(1'b1, 8'h24, 32'hff);
		chki(1'b0);
		code <= 4'h8;
		repeat (2) @(posedge pclk);
		chki(1'b1);
		rdc(8'h20, 32'hc0);
		apb(1'b1, 8'h24, 32'h00);
		chki(1'b0);
		apb(1'b1, 8'h24, 32'hff);
		chki(1'b1);
		apb(1'b1, 8'h28, 32'hff);
		chki(1'b0);
		rdc(8'h28, 32'h0);
		rdc(8'h20, 32'h0);
		{en, tmo, cnd.input_limit_active, cnd.charger_reverse} <= 4'he;
		cnd.line_voltage_present <= 1'b1;
		repeat (4) @(posedge pclk);
		rdc(8'h20, 32'h3f);
		chki(1'b1);
	endtask : t_irq
	initial
	begin
		{failures, cmp_count} = '0;
		{presetn, psel, penable, pwrite, en, ract, tmo} = 7'h0;
		{paddr, pwdata, code, lim} = '0;
		cnd = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_state();
		t_path();
		t_irq();
		conclude();
	end
endmodule : chgst_regs_tb
`default_nettype wire
